/* File: rtl/timer_zero_counter.sv */
// Purpose: Timer zero, an 8-bit period-match or 16-bit free-running counter.
// Assumes: All source inputs are levels synchronous to pclk, counted by edge.
// Notes:   Registers sit on APB; reads capture data in the setup cycle.
//
// What this block does
// - One width-select bit chooses between an 8-bit and a 16-bit counter.
// - The counter steps by one on each rising edge of the prescaled count clock.
// - A prescaler divides the selected source by two to the power of its select field.
// - In 8-bit width a buffered period copy is compared with the low byte each count.
// - On an 8-bit match the low byte clears and the buffer reloads from the high register.
// - In 16-bit width reading the low byte latches the upper count into the high register.
// - In 16-bit width a high write only fills a buffer that a low write moves into the count.
// - In 16-bit width the count wraps from all ones to zero and runs on.
// - Source codes 101, 100, 011, 010 pick secondary, low, high oscillators and sysclk/4.
// - Source codes 001 and 000 take the external pin, inverted and plain.
// - Software chooses synchronised or unsynchronised counting.
`timescale 1ns/1ps
module timer_zero_counter
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Count clock sources.
    input  wire logic        ext_pin,
    input  wire logic        secondary_oscillator,
    input  wire logic        low_freq_internal_osc,
    input  wire logic        high_freq_internal_osc
);

    ////////////////////////////////////////////////////////////////////////////
    // State.
    typedef struct packed {
        logic [3:0]                      prescale_select;
        logic                            counter_width_select;
        logic                            async_mode;
        timer_zero_pkg::clk_src_t        clock_source_select;
        logic [7:0]                      count_low_byte;
        logic [7:0]                      count_upper;
        logic [7:0]                      count_high_byte;
        logic [7:0]                      period_buf;
        logic                            flag;
        logic [31:0]                     rdata;
        logic                            src_q;
        logic                            pre_q;
        logic                            sync1;
        logic                            sync2;
        logic                            sync3;
        logic [timer_zero_pkg::DIV_W-1:0] div;
        logic [1:0]                      sys_div;
    } state_t;

    state_t st;
    state_t next_st;

    logic        src;
    logic        src_rise;
    logic        pre_clk;
    logic        tick;
    logic        match;
    logic        wrap;
    logic        evt;
    logic        setup;
    logic        rd_setup;
    logic        wr;
    logic        mapped;
    logic [15:0] count16;

    ////////////////////////////////////////////////////////////////////////////
    // Source select and prescaler.
    always_comb
    begin
        case (st.clock_source_select)
            timer_zero_pkg::CS_PIN:     src = ext_pin;
            timer_zero_pkg::CS_PIN_INV: src = ~ext_pin;
            timer_zero_pkg::CS_SYS_DV4: src = st.sys_div[1];
            timer_zero_pkg::CS_HF_OSC:  src = high_freq_internal_osc;
            timer_zero_pkg::CS_LF_OSC:  src = low_freq_internal_osc;
            timer_zero_pkg::CS_SEC_OSC: src = secondary_oscillator;
            default:                    src = 1'b0;
        endcase
    end

    assign src_rise = src & ~st.src_q;
    // A ratio of one passes the source straight through; others tap the divider.
    assign pre_clk  = (st.prescale_select == 4'h0) ? src
                    : st.div[4'(st.prescale_select - 4'h1)];

    // The unsynchronised path saves two cycles of latency but sees the raw level.
    assign tick = st.async_mode ? (pre_clk & ~st.pre_q)
                                : (st.sync2 & ~st.sync3);

    assign count16 = {st.count_upper, st.count_low_byte};
    assign match   = st.count_low_byte == st.period_buf;
    assign wrap    = count16 == {timer_zero_pkg::BYTE_MAX, timer_zero_pkg::BYTE_MAX};
    assign evt     = tick & (st.counter_width_select ? wrap : match);

    ////////////////////////////////////////////////////////////////////////////
    // APB decode.
    assign setup    = psel & ~penable;
    assign rd_setup = setup & ~pwrite;
    assign wr       = psel & penable & pwrite;
    assign mapped   = (paddr == timer_zero_pkg::ADDR_CTRL) | (paddr == timer_zero_pkg::ADDR_LOW)
                    | (paddr == timer_zero_pkg::ADDR_HIGH) | (paddr == timer_zero_pkg::ADDR_STAT);
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mapped;
    assign prdata   = st.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb
    begin
        next_st         = st;
        next_st.src_q   = src;
        next_st.pre_q   = pre_clk;
        next_st.sync1   = pre_clk;
        next_st.sync2   = st.sync1;
        next_st.sync3   = st.sync2;
        next_st.sys_div = st.sys_div + 2'h1;
        if (src_rise)
        begin
            next_st.div = st.div + 15'h0001;
        end
        if (tick)
        begin
            if (st.counter_width_select)
            begin
                // Rolls over from all ones to zero.
                {next_st.count_upper, next_st.count_low_byte} = count16 + 16'h0001;
            end
            else if (match)
            begin
                next_st.count_low_byte = timer_zero_pkg::BYTE_ZERO;
                next_st.period_buf     = st.count_high_byte;
            end
            else
            begin
                next_st.count_low_byte = st.count_low_byte + 8'h01;
            end
        end
        if (rd_setup)
        begin
            case (paddr)
                timer_zero_pkg::ADDR_CTRL:
                begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rdata[timer_zero_pkg::PS_LSB +: timer_zero_pkg::PS_W] =
                        st.prescale_select;
                    next_st.rdata[timer_zero_pkg::WIDTH_BIT] = st.counter_width_select;
                    next_st.rdata[timer_zero_pkg::ASYNC_BIT] = st.async_mode;
                    next_st.rdata[timer_zero_pkg::CS_LSB +: timer_zero_pkg::CS_W] =
                        st.clock_source_select;
                end
                timer_zero_pkg::ADDR_LOW:
                begin
                    next_st.rdata = {24'h00_0000, st.count_low_byte};
                    if (st.counter_width_select)
                    begin
                        next_st.count_high_byte = st.count_upper;
                    end
                end
                timer_zero_pkg::ADDR_HIGH: next_st.rdata = {24'h00_0000, st.count_high_byte};
                timer_zero_pkg::ADDR_STAT: next_st.rdata = {31'h0000_0000, st.flag};
                default:                   next_st.rdata = 32'h0000_0000;
            endcase
        end
        if (wr)
        begin
            case (paddr)
                timer_zero_pkg::ADDR_CTRL:
                begin
                    next_st.prescale_select =
                        pwdata[timer_zero_pkg::PS_LSB +: timer_zero_pkg::PS_W];
                    next_st.counter_width_select = pwdata[timer_zero_pkg::WIDTH_BIT];
                    next_st.async_mode           = pwdata[timer_zero_pkg::ASYNC_BIT];
                    next_st.clock_source_select  = timer_zero_pkg::clk_src_t'(
                        pwdata[timer_zero_pkg::CS_LSB +: timer_zero_pkg::CS_W]);
                end
                timer_zero_pkg::ADDR_LOW:
                begin
                    // A software write beats a count in the same cycle.
                    next_st.count_low_byte = pwdata[7:0];
                    if (st.counter_width_select)
                    begin
                        next_st.count_upper = st.count_high_byte;
                    end
                end
                timer_zero_pkg::ADDR_HIGH: next_st.count_high_byte = pwdata[7:0];
                timer_zero_pkg::ADDR_STAT:
                begin
                    if (pwdata[timer_zero_pkg::FLAG_BIT])
                    begin
                        next_st.flag = 1'b0;
                    end
                end
                default: next_st.flag = st.flag;
            endcase
        end
        if (evt)
        begin
            next_st.flag = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '{count_high_byte:     timer_zero_pkg::HIGH_RST,
                    period_buf:          timer_zero_pkg::HIGH_RST,
                    clock_source_select: timer_zero_pkg::CS_PIN,
                    default:             '0};
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic wr_low;
    logic wr_high;
    assign wr_low  = wr & (paddr == timer_zero_pkg::ADDR_LOW);
    assign wr_high = wr & (paddr == timer_zero_pkg::ADDR_HIGH);

    property p_step8;
        tick && !st.counter_width_select && !match && !wr_low
        |=> st.count_low_byte == $past(st.count_low_byte) + 8'h01;
    endproperty
    a_step8: assert property (p_step8) else $error("8-bit count did not step");

    property p_match;
        tick && !st.counter_width_select && match && !wr_low && !wr_high
        |=> st.count_low_byte == 8'h00 && st.period_buf == $past(st.count_high_byte) && st.flag;
    endproperty
    a_match: assert property (p_match) else $error("period match mishandled");

    property p_hold8;
        !tick && !wr_low && !st.counter_width_select |=> $stable(st.count_low_byte);
    endproperty
    a_hold8: assert property (p_hold8) else $error("count moved without a tick");

    property p_latch;
        rd_setup && paddr == timer_zero_pkg::ADDR_LOW && st.counter_width_select
        |=> st.count_high_byte == $past(st.count_upper) && prdata[7:0] == $past(st.count_low_byte);
    endproperty
    a_latch: assert property (p_latch) else $error("high byte not latched on low read");

    sequence s_low_write16;
        wr_low && st.counter_width_select;
    endsequence
    sequence s_high_write16;
        wr_high && st.counter_width_select && !tick;
    endsequence
    property p_coherent_write;
        s_low_write16
        |=> st.count_upper == $past(st.count_high_byte) && st.count_low_byte == $past(pwdata[7:0]);
    endproperty
    a_coherent_write: assert property (p_coherent_write) else $error("buffered high lost");

    property p_high_buffered;
        s_high_write16 |=> st.count_upper == $past(st.count_upper);
    endproperty
    a_high_buffered: assert property (p_high_buffered) else $error("high write hit count");

    property p_wrap;
        tick && st.counter_width_select && wrap && !wr_low
        |=> count16 == 16'h0000 && st.flag;
    endproperty
    a_wrap: assert property (p_wrap) else $error("16-bit wrap mishandled");

    property p_src_inv;
        st.clock_source_select == timer_zero_pkg::CS_PIN_INV |-> src == !ext_pin;
    endproperty
    a_src_inv: assert property (p_src_inv) else $error("inverted pin not selected");

    property p_src_sec;
        st.clock_source_select == timer_zero_pkg::CS_SEC_OSC |-> src == secondary_oscillator;
    endproperty
    a_src_sec: assert property (p_src_sec) else $error("secondary source not selected");

    sequence s_sync_rise;
        !st.async_mode && pre_clk && !st.pre_q ##1 (!st.async_mode && pre_clk) [*2];
    endsequence
    property p_sync_delay;
        s_sync_rise |-> tick;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("synchroniser delay wrong");

    property p_async;
        st.async_mode && pre_clk && !st.pre_q && st.counter_width_select && !wr_low
        |=> count16 == $past(count16) + 16'h0001;
    endproperty
    a_async: assert property (p_async) else $error("async edge not counted");

    property p_flag_sticky;
        st.flag && !(wr && paddr == timer_zero_pkg::ADDR_STAT && pwdata[timer_zero_pkg::FLAG_BIT])
        |=> st.flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

endmodule // timer_zero_counter

/* File: rtl/timer_zero_pkg.sv */
// Purpose: Shared constants for the timer zero counter block.
// Assumes: APB slave with 32-bit data and byte addresses on paddr.
// Notes:   Register offsets are used by design and bench; field positions by the design only.
package timer_zero_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LOW  = 8'h04;
    localparam logic [7:0] ADDR_HIGH = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;

    ////////////////////////////////////////////////////////////////////////////
    // Control and status register fields.
    localparam int PS_LSB    = 0;
    localparam int PS_W      = 4;
    localparam int WIDTH_BIT = 4;
    localparam int ASYNC_BIT = 5;
    localparam int CS_LSB    = 8;
    localparam int CS_W      = 3;
    localparam int FLAG_BIT  = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Widths and reset values.
    localparam int         DIV_W     = 15;
    localparam logic [7:0] HIGH_RST  = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_MAX  = 8'hFF;

    ////////////////////////////////////////////////////////////////////////////
    // Count clock sources.
    typedef enum logic [2:0] {
        CS_PIN     = 3'b000,
        CS_PIN_INV = 3'b001,
        CS_SYS_DV4 = 3'b010,
        CS_HF_OSC  = 3'b011,
        CS_LF_OSC  = 3'b100,
        CS_SEC_OSC = 3'b101,
        CS_RSV_6   = 3'b110,
        CS_RSV_7   = 3'b111
    } clk_src_t;

endpackage

/* File: testbench/clock_source_model.sv */
// Purpose: Partner model of the count sources: the routed pin and three oscillators.
// Assumes: Source lines are levels sampled on pclk by the timer.
// Notes:   Lines stand low between bursts, so no stray edge is ever counted.
`timescale 1ns/1ps
module clock_source_model
(
    // Clock.
    input  wire logic pclk,
    // Source lines.
    output logic      ext_pin,
    output logic      secondary_oscillator,
    output logic      low_freq_internal_osc,
    output logic      high_freq_internal_osc
);
    logic [3:0] lines = 4'h0;

    assign ext_pin                = lines[0];
    assign secondary_oscillator   = lines[1];
    assign low_freq_internal_osc  = lines[2];
    assign high_freq_internal_osc = lines[3];

    ////////////////////////////////////////////////////////////////////////////
    // Each pulse is two cycles high and two low, so both levels outlast one pclk.
    task automatic burst(input int which, input int n);
        repeat (n)
        begin
            @(posedge pclk);
            lines[which] <= 1'b1;
            @(posedge pclk);
            @(posedge pclk);
            lines[which] <= 1'b0;
            @(posedge pclk);
        end
    endtask
endmodule // clock_source_model

/* File: testbench/tb.sv */
// Purpose: Self-checking bench for the timer zero counter.
// Assumes: APB slave answers by pready; sources come from the partner model.
// Notes:   Counts are read back over APB after each burst of source edges.
`timescale 1ns/1ps
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
    // Clock, reset and APB.
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    // Source lines.
    logic        ext_pin;
    logic        secondary_oscillator;
    logic        low_freq_internal_osc;
    logic        high_freq_internal_osc;
    // Bench state.
    int          num_errors  = 0;
    int          check_count = 0;
    logic [31:0] rd;
    logic [31:0] v1;
    logic        err;
    logic [2:0]  codes [7] = '{3'b001, 3'b000, 3'b101, 3'b100, 3'b011, 3'b110, 3'b111};

    timer_zero_counter i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_pin(ext_pin), .secondary_oscillator(secondary_oscillator),
        .low_freq_internal_osc(low_freq_internal_osc),
        .high_freq_internal_osc(high_freq_internal_osc));

    clock_source_model i_src (.pclk(pclk), .ext_pin(ext_pin),
        .secondary_oscillator(secondary_oscillator),
        .low_freq_internal_osc(low_freq_internal_osc),
        .high_freq_internal_osc(high_freq_internal_osc));

    initial
    begin
        forever #12.5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus tasks. One idle cycle follows each transfer so no signal is set twice.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 100)
        begin
            n++;
            @(posedge pclk);
        end
        if (n == 100)
            num_errors++;
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        `CHECK({err, rd}, {1'b0, exp})
    endtask

    function automatic logic [31:0] ctrl(logic [2:0] cs, logic as, logic w, logic [3:0] ps);
        return {21'h0, cs, 2'b00, as, w, ps};
    endfunction

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    // Loads a zero count with the source idle, bursts, then reads the count back.
    task automatic run_src(input logic [2:0] cs, input logic as, input logic [3:0] ps,
                           input int n, input logic [7:0] exp);
        apb(1'b1, timer_zero_pkg::ADDR_CTRL, ctrl(cs, as, 1'b1, ps));
        apb(1'b1, timer_zero_pkg::ADDR_HIGH, 32'h0000_0000);
        apb(1'b1, timer_zero_pkg::ADDR_LOW, 32'h0000_0000);
        i_src.burst((cs < 3'b010) ? 0 : (cs == 3'b101) ? 1 : (cs == 3'b100) ? 2 : 3, n);
        repeat (4) @(posedge pclk);
        rd_chk(timer_zero_pkg::ADDR_LOW, {24'h0, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Tests.
    initial
    begin
        do_reset();
        rd_chk(timer_zero_pkg::ADDR_CTRL, 32'h0000_0000);
        rd_chk(timer_zero_pkg::ADDR_HIGH, 32'h0000_00FF);
        rd_chk(timer_zero_pkg::ADDR_STAT, 32'h0000_0000);
        apb(1'b0, 8'h10, 32'h0000_0000);
        `CHECK({err, rd}, {1'b1, 32'h0000_0000})
        for (int s = 0; s < 7; s++)
            for (int a = 0; a < 2; a++)
                run_src(codes[s], a[0], 4'h0, 10, (s >= 5) ? 8'h00 : 8'h0A);
        // The system divided source runs free, so the window allows one tick of phase.
        apb(1'b1, timer_zero_pkg::ADDR_CTRL, ctrl(3'b010, 1'b1, 1'b1, 4'h0));
        apb(1'b0, timer_zero_pkg::ADDR_LOW, 32'h0000_0000);
        v1 = rd;
        repeat (40) @(posedge pclk);
        apb(1'b0, timer_zero_pkg::ADDR_LOW, 32'h0000_0000);
        `CHECK((rd - v1) inside {32'h0000_000A, 32'h0000_000B}, 1'b1)
        // A second reset starts the prescaler from zero.
        do_reset();
        run_src(3'b000, 1'b1, 4'h2, 16, 8'h04);
        // Eight-bit width: the first pass runs out the reset period, then period three.
        apb(1'b1, timer_zero_pkg::ADDR_CTRL, ctrl(3'b000, 1'b1, 1'b0, 4'h0));
        apb(1'b1, timer_zero_pkg::ADDR_HIGH, 32'h0000_0003);
        apb(1'b1, timer_zero_pkg::ADDR_LOW, 32'h0000_00FE);
        i_src.burst(0, 7);
        repeat (4) @(posedge pclk);
        rd_chk(timer_zero_pkg::ADDR_LOW, 32'h0000_0001);
        rd_chk(timer_zero_pkg::ADDR_HIGH, 32'h0000_0003);
        rd_chk(timer_zero_pkg::ADDR_STAT, 32'h0000_0001);
        apb(1'b1, timer_zero_pkg::ADDR_STAT, 32'h0000_0001);
        rd_chk(timer_zero_pkg::ADDR_STAT, 32'h0000_0000);
        // Sixteen-bit width: wrap, coherent read, buffered high write.
        apb(1'b1, timer_zero_pkg::ADDR_CTRL, ctrl(3'b000, 1'b1, 1'b1, 4'h0));
        apb(1'b1, timer_zero_pkg::ADDR_HIGH, 32'h0000_00FF);
        apb(1'b1, timer_zero_pkg::ADDR_LOW, 32'h0000_00FE);
        i_src.burst(0, 3);
        repeat (4) @(posedge pclk);
        rd_chk(timer_zero_pkg::ADDR_LOW, 32'h0000_0001);
        rd_chk(timer_zero_pkg::ADDR_HIGH, 32'h0000_0000);
        rd_chk(timer_zero_pkg::ADDR_STAT, 32'h0000_0001);
        apb(1'b1, timer_zero_pkg::ADDR_HIGH, 32'h0000_0012);
        i_src.burst(0, 1);
        repeat (4) @(posedge pclk);
        rd_chk(timer_zero_pkg::ADDR_LOW, 32'h0000_0002);
        rd_chk(timer_zero_pkg::ADDR_HIGH, 32'h0000_0000);
        apb(1'b1, timer_zero_pkg::ADDR_HIGH, 32'h0000_0012);
        apb(1'b1, timer_zero_pkg::ADDR_LOW, 32'h0000_0034);
        rd_chk(timer_zero_pkg::ADDR_LOW, 32'h0000_0034);
        rd_chk(timer_zero_pkg::ADDR_HIGH, 32'h0000_0012);
        final_report();
    end

    // The tests take under 3000 cycles; the watchdog allows ten times that.
    initial
    begin
        #(25 * 30000);
        num_errors++;
        final_report();
    end

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
endmodule // tb
